// ### efr_bus_regs.vh
`ifndef EFR_BUS_REGS_VH
`define EFR_BUS_REGS_VH

// transfer width codes on xfer_width_code
`define EFR_SZ_LONG 2'h0
`define EFR_SZ_BYTE 2'h1
`define EFR_SZ_WORD 2'h2
`define EFR_SZ_LINE 2'h3

// window port size codes
`define EFR_PS_32 2'h0
`define EFR_PS_8 2'h1
`define EFR_PS_16 2'h2

// per-window parameter byte: [1:0] port, [5:2] waits, [6] internal ack, [7] burst
`define EFR_WP_PORT_LSB 0
`define EFR_WP_WAIT_LSB 2
`define EFR_WP_AUTO_BIT 6
`define EFR_WP_BURST_BIT 7
`define EFR_WP_WIDTH 8

// windows compare address bits [31:16]
`define EFR_WIN_ABITS 16
`define EFR_NUM_CS 8
`define EFR_NUM_DRAM 2

// bus clock half period in mclk cycles; four so a pin set after the fall clears the synchroniser
`define EFR_BCLK_HALF 4

`endif

// ### efr_win_match.v
`timescale 1ns/1ps
`include "efr_bus_regs.vh"

module efr_win_match (
    // address under test
    input wire [31:0] addr_i,
    // chip-select windows
    input wire [8*16-1:0] cs_base_i,
    input wire [8*16-1:0] cs_mask_i,
    input wire [7:0] cs_valid_i,
    input wire [8*8-1:0] cs_param_i,
    // dram windows
    input wire [2*16-1:0] dram_base_i,
    input wire [2*16-1:0] dram_mask_i,
    input wire [1:0] dram_valid_i,
    input wire [2*8-1:0] dram_param_i,
    // match result
    output reg [7:0] cs_hit_o,
    output reg [1:0] dram_hit_o,
    output reg [7:0] param_o
);

    integer i;
    reg [3:0] cs_cnt;
    reg [1:0] dr_cnt;

    // mask bits set to one exclude that address bit from the compare
    function hit;
        input [15:0] a;
        input [15:0] b;
        input [15:0] m;
        begin
            hit = (((a ^ b) & ~m) == 16'h0000);
        end
    endfunction

    always @* begin
        cs_cnt = 4'h0;
        dr_cnt = 2'h0;
        param_o = {1'b0, 1'b0, 4'h0, `EFR_PS_32};
        for (i = 0; i < 8; i = i + 1) begin
            cs_hit_o[i] = cs_valid_i[i] & hit(addr_i[31:16], cs_base_i[i*16 +: 16],
                                              cs_mask_i[i*16 +: 16]);
            cs_cnt = cs_cnt + {3'h0, cs_hit_o[i]};
        end
        for (i = 0; i < 2; i = i + 1) begin
            dram_hit_o[i] = dram_valid_i[i] & hit(addr_i[31:16], dram_base_i[i*16 +: 16],
                                                  dram_mask_i[i*16 +: 16]);
            dr_cnt = dr_cnt + {1'b0, dram_hit_o[i]};
        end
        // single hit takes its window's settings; none, several or overlaps fall back
        // to an external, burst-inhibited 32-bit cycle
        if (cs_cnt == 4'h1 && dr_cnt == 2'h0) begin
            for (i = 0; i < 8; i = i + 1) begin
                if (cs_hit_o[i]) begin
                    param_o = cs_param_i[i*8 +: 8];
                end
            end
        end else if (cs_cnt == 4'h0 && dr_cnt == 2'h1) begin
            for (i = 0; i < 2; i = i + 1) begin
                if (dram_hit_o[i]) begin
                    param_o = dram_param_i[i*8 +: 8];
                end
            end
        end
        // overlapping dram matches are left unselected; configuration must avoid them
        if (dr_cnt != 2'h1 || cs_cnt != 4'h0) begin
            dram_hit_o = 2'h0;
        end
        if (dr_cnt != 2'h0) begin
            cs_hit_o = 8'h00;
        end
    end

endmodule // efr_win_match

// ### efr_bus_ctrl.v
`timescale 1ns/1ps
`include "efr_bus_regs.vh"
// Functional notes
// - address, data, start, attributes change on rise
// - read data captured on bus rising edge
// - strobes, selects, enables switch on falling edge
// - byte/word/long operands; 8/16/32-bit ports
// - burst keeps full transfer size code
// - no burst: full size, then port size
// - width codes long 00 byte 01 word 10
// - 8-bit port on top lane, MSB first
// - compare address with all ten windows
// - single match uses that window's settings
// - no match: external, burst-inhibited, 32-bit
// - several chip selects: all driven, external 32-bit
// - three clocks; first drives address, start, strobe
// - read data sampled with ack, end clock two
// - write data from end clock one to end
// - late ack inserts wait states
// - internal ack when window enables it
// - last clock holds address, attributes, data
// - each window has port, waits, internal ack
// - start strobe negated at second clock
// - waits are whole clocks until ack sampled

module efr_bus_ctrl #(
    parameter BCLK_HALF = `EFR_BCLK_HALF
) (
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // transfer request
    input wire req_valid_i,
    output reg req_ready_o,
    input wire req_write_i,
    input wire [31:0] req_addr_i,
    input wire [1:0] req_size_i,
    input wire [1:0] req_type_i,
    input wire [2:0] req_mod_i,
    input wire [127:0] req_wdata_i,
    // transfer completion
    output reg resp_valid_o,
    output reg [127:0] resp_rdata_o,
    output reg [1:0] dram_blk_sel_o,
    // window configuration
    input wire [8*16-1:0] cs_base_i,
    input wire [8*16-1:0] cs_mask_i,
    input wire [7:0] cs_valid_i,
    input wire [8*8-1:0] cs_param_i,
    input wire [2*16-1:0] dram_base_i,
    input wire [2*16-1:0] dram_mask_i,
    input wire [1:0] dram_valid_i,
    input wire [2*8-1:0] dram_param_i,
    // bus clock and rising-edge pins
    output reg bus_clk_out_o,
    output reg [31:0] addr_o,
    output reg rw_n_o,
    output reg [1:0] xfer_width_code_o,
    output reg [1:0] xfer_type_o,
    output reg [2:0] xfer_modifier_o,
    output reg xfer_in_progress_n_o,
    output reg transfer_start_n_o,
    // falling-edge strobes
    output reg addr_strobe_n_o,
    output reg [7:0] chip_sel_n_o,
    output reg out_en_n_o,
    output reg [3:0] byte_lane_en_n_o,
    // data bus
    input wire [31:0] data_i,
    output reg [31:0] data_o,
    output reg data_oe_o,
    // acknowledge pin
    input wire transfer_ack_n_i,
    output reg transfer_ack_n_o,
    output reg transfer_ack_oe_o
);

    localparam ST_IDLE = 2'h0;
    localparam ST_ADDR = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam ST_HOLD = 2'h3;

    reg [7:0] cnt_q;
    reg [1:0] st_q;
    reg pend_q;
    reg wr_q;
    reg [31:0] ad_q;
    reg [1:0] size_q;
    reg [1:0] type_q;
    reg [2:0] mod_q;
    reg [1:0] port_q;
    reg [3:0] wait_q;
    reg [3:0] wcnt_q;
    reg auto_q;
    reg burst_q;
    reg [7:0] cs_hit_q;
    reg [1:0] dr_hit_q;
    reg [4:0] rem_q;
    reg [127:0] sh_q;
    reg ta_s1_q;
    reg ta_s2_q;
    reg [31:0] din_s1_q;
    reg [31:0] din_s2_q;

    wire [7:0] m_cs_hit;
    wire [1:0] m_dr_hit;
    wire [7:0] m_param;
    wire rise_en;
    wire fall_en;
    wire [2:0] pbytes;
    wire [2:0] bbytes;
    wire [1:0] ofs;
    wire acked;
    wire [31:0] rd_al;
    reg [127:0] acc_d;

    efr_win_match u_match (
        .addr_i(req_addr_i),
        .cs_base_i(cs_base_i),
        .cs_mask_i(cs_mask_i),
        .cs_valid_i(cs_valid_i),
        .cs_param_i(cs_param_i),
        .dram_base_i(dram_base_i),
        .dram_mask_i(dram_mask_i),
        .dram_valid_i(dram_valid_i),
        .dram_param_i(dram_param_i),
        .cs_hit_o(m_cs_hit),
        .dram_hit_o(m_dr_hit),
        .param_o(m_param)
    );

    // operand bytes for a width code
    function [4:0] size_bytes;
        input [1:0] sz;
        begin
            case (sz)
                `EFR_SZ_BYTE: size_bytes = 5'h01;
                `EFR_SZ_WORD: size_bytes = 5'h02;
                `EFR_SZ_LINE: size_bytes = 5'h10;
                default: size_bytes = 5'h04;
            endcase
        end
    endfunction

    // port bytes for a port code; the spare code acts as 32 bits
    function [2:0] port_bytes;
        input [1:0] ps;
        begin
            case (ps)
                `EFR_PS_8: port_bytes = 3'h1;
                `EFR_PS_16: port_bytes = 3'h2;
                default: port_bytes = 3'h4;
            endcase
        end
    endfunction

    // width code shown for a port-sized beat
    function [1:0] port_code;
        input [1:0] ps;
        begin
            case (ps)
                `EFR_PS_8: port_code = `EFR_SZ_BYTE;
                `EFR_PS_16: port_code = `EFR_SZ_WORD;
                default: port_code = `EFR_SZ_LONG;
            endcase
        end
    endfunction

    // bytes moved per beat: the smaller of operand and port
    function [2:0] beat_bytes;
        input [1:0] sz;
        input [1:0] ps;
        begin
            if (size_bytes(sz) < {2'h0, port_bytes(ps)}) begin
                beat_bytes = {1'b0, sz == `EFR_SZ_WORD, sz == `EFR_SZ_BYTE};
            end else begin
                beat_bytes = port_bytes(ps);
            end
        end
    endfunction

    assign rise_en = (cnt_q == BCLK_HALF - 1) && !bus_clk_out_o;
    assign fall_en = (cnt_q == BCLK_HALF - 1) && bus_clk_out_o;
    assign pbytes = port_bytes(port_q);
    assign bbytes = beat_bytes(size_q, port_q);
    // lane offset inside the port; lane 0 is the top byte of the bus
    assign ofs = ad_q[1:0] & (pbytes[1:0] - 2'h1 | {pbytes[2], pbytes[2]});
    assign acked = auto_q ? (wcnt_q == 4'h0) : !ta_s2_q;
    assign rd_al = din_s2_q << {ofs, 3'h0};

    // read accumulation, first beat ends up most significant
    always @* begin
        acc_d = resp_rdata_o;
        case (bbytes)
            3'h1: acc_d = {resp_rdata_o[119:0], rd_al[31:24]};
            3'h2: acc_d = {resp_rdata_o[111:0], rd_al[31:16]};
            default: acc_d = {resp_rdata_o[95:0], rd_al};
        endcase
    end

    // pins are asynchronous to mclk; a half period of four cycles leaves room for this
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ta_s1_q <= 1'b1;
            ta_s2_q <= 1'b1;
            din_s1_q <= 32'h00000000;
            din_s2_q <= 32'h00000000;
        end else begin
            ta_s1_q <= transfer_ack_n_i;
            ta_s2_q <= ta_s1_q;
            din_s1_q <= data_i;
            din_s2_q <= din_s1_q;
        end
    end

    // bus clock divider
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
            bus_clk_out_o <= 1'b0;
        end else if (cnt_q == BCLK_HALF - 1) begin
            cnt_q <= 8'h00;
            bus_clk_out_o <= !bus_clk_out_o;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // request intake, rising-edge state machine and pins
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            pend_q <= 1'b0;
            req_ready_o <= 1'b1;
            resp_valid_o <= 1'b0;
            resp_rdata_o <= 128'h0;
            dram_blk_sel_o <= 2'h0;
            wr_q <= 1'b0;
            ad_q <= 32'h00000000;
            size_q <= `EFR_SZ_LONG;
            type_q <= 2'h0;
            mod_q <= 3'h0;
            port_q <= `EFR_PS_32;
            wait_q <= 4'h0;
            wcnt_q <= 4'h0;
            auto_q <= 1'b0;
            burst_q <= 1'b0;
            cs_hit_q <= 8'h00;
            dr_hit_q <= 2'h0;
            rem_q <= 5'h00;
            sh_q <= 128'h0;
            addr_o <= 32'h00000000;
            rw_n_o <= 1'b1;
            xfer_width_code_o <= `EFR_SZ_LONG;
            xfer_type_o <= 2'h0;
            xfer_modifier_o <= 3'h0;
            xfer_in_progress_n_o <= 1'b1;
            transfer_start_n_o <= 1'b1;
            data_o <= 32'h00000000;
            data_oe_o <= 1'b0;
        end else begin
            resp_valid_o <= 1'b0;
            if (req_valid_i && req_ready_o) begin
                req_ready_o <= 1'b0;
                pend_q <= 1'b1;
                wr_q <= req_write_i;
                ad_q <= req_addr_i;
                size_q <= req_size_i;
                type_q <= req_type_i;
                mod_q <= req_mod_i;
                cs_hit_q <= m_cs_hit;
                dr_hit_q <= m_dr_hit;
                port_q <= m_param[`EFR_WP_PORT_LSB +: 2];
                wait_q <= m_param[`EFR_WP_WAIT_LSB +: 4];
                auto_q <= m_param[`EFR_WP_AUTO_BIT];
                burst_q <= m_param[`EFR_WP_BURST_BIT];
                // operand left-justified so the most significant byte leaves first
                sh_q <= req_wdata_i << {(5'h10 - size_bytes(req_size_i)), 3'h0};
            end
            if (rise_en) begin
                case (st_q)
                    ST_IDLE: begin
                        if (pend_q) begin
                            pend_q <= 1'b0;
                            st_q <= ST_ADDR;
                            rem_q <= size_bytes(size_q) >> (bbytes >> 1);
                            dram_blk_sel_o <= dr_hit_q;
                            resp_rdata_o <= 128'h0;
                            addr_o <= ad_q;
                            rw_n_o <= !wr_q;
                            xfer_width_code_o <= size_q;
                            xfer_type_o <= type_q;
                            xfer_modifier_o <= mod_q;
                            xfer_in_progress_n_o <= 1'b0;
                            transfer_start_n_o <= 1'b0;
                            wcnt_q <= wait_q;
                        end
                    end
                    ST_ADDR: begin
                        transfer_start_n_o <= 1'b1;
                        st_q <= ST_DATA;
                        if (wr_q) begin
                            data_o <= sh_q[127:96] >> {ofs, 3'h0};
                            data_oe_o <= 1'b1;
                        end
                    end
                    ST_DATA: begin
                        if (!acked) begin
                            if (auto_q) begin
                                wcnt_q <= wcnt_q - 4'h1;
                            end
                        end else begin
                            if (!wr_q) begin
                                resp_rdata_o <= acc_d;
                            end
                            rem_q <= rem_q - 5'h01;
                            sh_q <= sh_q << {bbytes, 3'h0};
                            if (burst_q && rem_q != 5'h01) begin
                                wcnt_q <= wait_q;
                                if (wr_q) begin
                                    data_o <= sh_q[7'd127 - {bbytes, 3'h0} -: 32];
                                end
                            end else begin
                                st_q <= ST_HOLD;
                            end
                        end
                    end
                    default: begin
                        data_oe_o <= 1'b0;
                        if (rem_q != 5'h00) begin
                            st_q <= ST_ADDR;
                            ad_q <= ad_q + {29'h0, bbytes};
                            addr_o <= ad_q + {29'h0, bbytes};
                            xfer_width_code_o <= port_code(port_q);
                            transfer_start_n_o <= 1'b0;
                            wcnt_q <= wait_q;
                        end else begin
                            st_q <= ST_IDLE;
                            xfer_in_progress_n_o <= 1'b1;
                            dram_blk_sel_o <= 2'h0;
                            resp_valid_o <= 1'b1;
                            req_ready_o <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // falling-edge strobes and internal acknowledge
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_strobe_n_o <= 1'b1;
            chip_sel_n_o <= 8'hFF;
            out_en_n_o <= 1'b1;
            byte_lane_en_n_o <= 4'hF;
            transfer_ack_n_o <= 1'b1;
            transfer_ack_oe_o <= 1'b0;
        end else if (fall_en) begin
            if (st_q == ST_ADDR || st_q == ST_DATA) begin
                addr_strobe_n_o <= 1'b0;
                chip_sel_n_o <= ~cs_hit_q;
                out_en_n_o <= wr_q;
                byte_lane_en_n_o <= ~((4'hF >> (3'h4 - bbytes)) << ofs);
            end else begin
                addr_strobe_n_o <= 1'b1;
                chip_sel_n_o <= 8'hFF;
                out_en_n_o <= 1'b1;
                byte_lane_en_n_o <= 4'hF;
            end
            // drive ack through the low phase before the rise that ends the wait
            if (st_q == ST_DATA && auto_q && wcnt_q == 4'h0) begin
                transfer_ack_n_o <= 1'b0;
                transfer_ack_oe_o <= 1'b1;
            end else begin
                transfer_ack_n_o <= 1'b1;
                transfer_ack_oe_o <= 1'b0;
            end
        end
    end

endmodule // efr_bus_ctrl

// ### efr_bus_ctrl_sva.sv
`timescale 1ns/1ps
module efr_bus_ctrl_sva #(
    parameter BCLK_HALF = 4
) (
    // clock and reset
    input logic mclk_i,
    input logic rst_i,
    // request side
    input logic req_ready_o,
    input logic resp_valid_o,
    input logic [127:0] resp_rdata_o,
    // bus pins
    input logic bus_clk_out_o,
    input logic [31:0] addr_o,
    input logic rw_n_o,
    input logic [1:0] xfer_width_code_o,
    input logic transfer_start_n_o,
    input logic addr_strobe_n_o,
    input logic [7:0] chip_sel_n_o,
    input logic out_en_n_o,
    input logic [3:0] byte_lane_en_n_o,
    input logic [31:0] data_o,
    input logic data_oe_o,
    input logic transfer_ack_oe_o
);
    localparam int HP = BCLK_HALF;
    localparam int BP = 2 * BCLK_HALF;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence rise_s; $rose(bus_clk_out_o); endsequence
    sequence fall_s; $fell(bus_clk_out_o); endsequence
    sequence start_s; $fell(transfer_start_n_o); endsequence
    rise_pins_a: assert property (
        !$stable({addr_o, rw_n_o, xfer_width_code_o, transfer_start_n_o}) |-> rise_s)
        else $error("address or attribute moved off bus rise");
    wdata_rise_a: assert property (
        !$stable(data_o) |-> rise_s) else $error("write data moved off bus rise");
    rdata_rise_a: assert property (
        !$stable(resp_rdata_o) |-> rise_s) else $error("read data taken off bus rise");
    strobe_fall_a: assert property (
        !$stable({addr_strobe_n_o, chip_sel_n_o, out_en_n_o, byte_lane_en_n_o}) |-> fall_s)
        else $error("strobe moved off bus fall");
    strobe_after_start_a: assert property (
        start_s |-> ##HP $fell(addr_strobe_n_o)) else $error("strobe not at first fall");
    start_width_a: assert property (
        start_s |-> ##BP $rose(transfer_start_n_o)) else $error("start not one bus clock");
    hold_stable_a: assert property (
        $fell(addr_strobe_n_o) |=> $stable({addr_o, rw_n_o, xfer_width_code_o})[*8])
        else $error("address moved before hold end");
    wdata_drive_a: assert property (
        $rose(data_oe_o) |-> $rose(transfer_start_n_o) && !rw_n_o ##1 $stable(data_o)[*7])
        else $error("write data window wrong");
    start_idle_a: assert property (
        start_s |-> addr_strobe_n_o && $past(addr_strobe_n_o, HP - 1))
        else $error("new cycle before hold clock");
    done_ready_a: assert property (
        resp_valid_o |-> req_ready_o ##1 !resp_valid_o) else $error("done pulse wrong");
    multi_ext_a: assert property (
        !$onehot0(~chip_sel_n_o) |-> !transfer_ack_oe_o) else $error("internal ack on multi match");
endmodule // efr_bus_ctrl_sva

// ### efr_ext_mem.sv
`timescale 1ns/1ps
module efr_ext_mem (
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // device side
    input wire bclk_i,
    input wire as_n_i,
    input wire rw_n_i,
    input wire [31:0] addr_i,
    input wire [31:0] dout_i,
    input wire doe_i,
    input wire ack_n_i,
    input wire ack_oe_i,
    // behaviour
    input wire ext_en_i,
    input wire [3:0] waits_i,
    // resolved pins
    output wire [31:0] data_pin_o,
    output wire ack_pin_o,
    output reg [31:0] wr_sh_o
);
    reg bclk_q;
    reg [3:0] fall_q;
    reg ack_q;
    reg [31:0] last_q;
    wire [7:0] ab = addr_i[7:0];
    wire rd_drv = !as_n_i && rw_n_i && fall_q != 4'h0;
    wire [31:0] rd = {ab ^ 8'h5A, ab ^ 8'h3C, addr_i[15:8], 8'hC3};
    // undriven data shows the inverse of the last level: no keeper on the bus
    assign data_pin_o = doe_i ? dout_i : rd_drv ? rd : ~last_q;
    // ack line has a pull-up when nobody drives it
    assign ack_pin_o = ack_oe_i ? ack_n_i : ~ack_q;
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            bclk_q <= 1'b0;
            fall_q <= 4'h0;
            ack_q <= 1'b0;
            last_q <= 32'h0;
            wr_sh_o <= 32'h0;
        end else begin
            bclk_q <= bclk_i;
            last_q <= data_pin_o;
            if (as_n_i)
                fall_q <= 4'h0;
            else if (bclk_q && !bclk_i)
                fall_q <= fall_q + 4'h1;
            if (bclk_i) begin
                ack_q <= 1'b0;
            end else if (bclk_q && ext_en_i && !as_n_i && fall_q == waits_i + 4'h1) begin
                ack_q <= 1'b1;
                if (!rw_n_i)
                    wr_sh_o <= {wr_sh_o[23:0], data_pin_o[31:24]};
            end
        end
    end
endmodule // efr_ext_mem

// ### external_bus_transfer_ctrl_tb_top.sv
`timescale 1ns/1ps
bind efr_bus_ctrl efr_bus_ctrl_sva #(.BCLK_HALF(BCLK_HALF)) u_efr_bus_ctrl_sva (.mclk_i, .rst_i,
    .req_ready_o, .resp_valid_o, .resp_rdata_o, .bus_clk_out_o, .addr_o, .rw_n_o,
    .xfer_width_code_o, .transfer_start_n_o, .addr_strobe_n_o, .chip_sel_n_o, .out_en_n_o,
    .byte_lane_en_n_o, .data_o, .data_oe_o, .transfer_ack_oe_o);
module external_bus_transfer_ctrl_tb_top;
    reg mclk_i = 0, rst_i = 1, req_valid_i = 0, req_write_i = 0, m_ext = 0, clr = 0, ts_q = 1;
    reg [31:0] req_addr_i = 0;
    reg [1:0] req_size_i = 0, req_type_i = 0, dram_valid_i = 0;
    reg [2:0] req_mod_i = 0;
    reg [127:0] req_wdata_i = 0;
    reg [127:0] cs_base_i = 128'h1001_1000, cs_mask_i = 0;
    reg [7:0] cs_valid_i = 0;
    reg [63:0] cs_param_i = 0;
    reg [31:0] dram_base_i = 32'h0000_4000, dram_mask_i = 0;
    reg [15:0] dram_param_i = 0;
    reg [3:0] m_w = 0;
    wire req_ready_o, resp_valid_o, bus_clk_out_o, rw_n_o, xfer_in_progress_n_o;
    wire transfer_start_n_o, addr_strobe_n_o, out_en_n_o, data_oe_o, transfer_ack_n_i;
    wire transfer_ack_n_o, transfer_ack_oe_o;
    wire [127:0] resp_rdata_o;
    wire [1:0] dram_blk_sel_o, xfer_width_code_o, xfer_type_o;
    wire [2:0] xfer_modifier_o;
    wire [7:0] chip_sel_n_o;
    wire [3:0] byte_lane_en_n_o;
    wire [31:0] addr_o, data_o, data_i, wr_sh;
    reg [7:0] cs_seen;
    reg oe_seen;
    reg [1:0] dr_seen, w_and;
    reg [1:0] ws [0:7];
    integer nts, tip_cnt, error_cnt = 0, n_checks = 0;
    always #2 mclk_i = ~mclk_i;
    efr_bus_ctrl u_efr_bus_ctrl (.mclk_i, .rst_i, .req_valid_i, .req_ready_o, .req_write_i,
        .req_addr_i, .req_size_i, .req_type_i, .req_mod_i, .req_wdata_i, .resp_valid_o,
        .resp_rdata_o, .dram_blk_sel_o, .cs_base_i, .cs_mask_i, .cs_valid_i, .cs_param_i,
        .dram_base_i, .dram_mask_i, .dram_valid_i, .dram_param_i, .bus_clk_out_o, .addr_o,
        .rw_n_o, .xfer_width_code_o, .xfer_type_o, .xfer_modifier_o, .xfer_in_progress_n_o,
        .transfer_start_n_o, .addr_strobe_n_o, .chip_sel_n_o, .out_en_n_o, .byte_lane_en_n_o,
        .data_i, .data_o, .data_oe_o, .transfer_ack_n_i, .transfer_ack_n_o, .transfer_ack_oe_o);
    efr_ext_mem u_efr_ext_mem (.mclk_i(mclk_i), .rst_i(rst_i), .bclk_i(bus_clk_out_o),
        .as_n_i(addr_strobe_n_o), .rw_n_i(rw_n_o), .addr_i(addr_o), .dout_i(data_o),
        .doe_i(data_oe_o), .ack_n_i(transfer_ack_n_o), .ack_oe_i(transfer_ack_oe_o),
        .ext_en_i(m_ext), .waits_i(m_w), .data_pin_o(data_i), .ack_pin_o(transfer_ack_n_i),
        .wr_sh_o(wr_sh));
    // bus monitor, cleared at each request
    always @(posedge mclk_i) begin
        ts_q <= transfer_start_n_o;
        if (clr) begin
            cs_seen <= 8'hFF; oe_seen <= 1'b0; dr_seen <= 2'h0; w_and <= 2'h3;
            nts <= 0; tip_cnt <= 0;
        end else begin
            cs_seen <= cs_seen & chip_sel_n_o;
            oe_seen <= oe_seen | transfer_ack_oe_o;
            dr_seen <= dr_seen | dram_blk_sel_o;
            if (!xfer_in_progress_n_o) begin
                tip_cnt <= tip_cnt + 1; w_and <= w_and & xfer_width_code_o;
            end
            if (ts_q && !transfer_start_n_o) begin
                ws[nts[2:0]] <= xfer_width_code_o; nts <= nts + 1;
            end
        end
    end
    function [31:0] rd(input [31:0] a);
        rd = {a[7:0] ^ 8'h5A, a[7:0] ^ 8'h3C, a[15:8], 8'hC3};
    endfunction
    task close_out; begin
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    end endtask
    task chk(input [63:0] nm, input [127:0] e, input [127:0] g); begin
        n_checks = n_checks + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("mismatch %0s expected %h seen %h", nm, e, g);
        end
    end endtask
    task cfg(input [7:0] v, input [7:0] p, input [15:0] m, input dv, input e, input [3:0] w);
    begin
        cs_valid_i <= v; cs_param_i <= {8{p}}; cs_mask_i <= {8{m}};
        dram_valid_i <= {1'b0, dv}; dram_param_i <= {2{p}}; m_ext <= e; m_w <= w;
    end endtask
    task run(input w, input [31:0] a, input [1:0] sz, input [127:0] wd);
        integer i;
    begin
        clr <= 1'b1; req_valid_i <= 1'b1; req_write_i <= w; req_addr_i <= a;
        req_size_i <= sz; req_wdata_i <= wd; req_type_i <= sz; req_mod_i <= {w, sz};
        @(posedge mclk_i);
        clr <= 1'b0; req_valid_i <= 1'b0;
        for (i = 0; i < 400 && resp_valid_o !== 1'b1; i = i + 1) @(negedge mclk_i);
        if (i == 400) begin
            error_cnt = error_cnt + 1;
            $display("mismatch done expected 1 seen timeout");
            close_out;
        end
        @(posedge mclk_i);
    end endtask
    task t_read32; begin
        cfg(8'h01, 8'h14, 16'h0, 1'b0, 1'b1, 4'h0);
        run(1'b0, 32'h1000_0004, 2'h0, 128'h0);
        chk("rdata", rd(32'h1000_0004), resp_rdata_o);
        chk("cs_n", 8'hFE, cs_seen);
        chk("tip", 24, tip_cnt);
        chk("width", 2'h0, ws[0]);
    end endtask
    task t_wait; begin
        cfg(8'h01, 8'h00, 16'h0, 1'b0, 1'b1, 4'h3);
        run(1'b0, 32'h1000_0008, 2'h0, 128'h0);
        chk("tip", 48, tip_cnt);
        chk("rdata", rd(32'h1000_0008), resp_rdata_o);
    end endtask
    task t_int_ack; begin
        cfg(8'h01, 8'h48, 16'h0, 1'b0, 1'b0, 4'h0);
        run(1'b0, 32'h1000_000C, 2'h0, 128'h0);
        chk("tip", 40, tip_cnt);
        chk("ack_oe", 1'b1, oe_seen);
        chk("rdata", rd(32'h1000_000C), resp_rdata_o);
    end endtask
    task t_port8; begin
        cfg(8'h01, 8'h01, 16'h0, 1'b0, 1'b1, 4'h0);
        run(1'b0, 32'h1000_0000, 2'h0, 128'h0);
        chk("rdata", 32'h5A5B_5859, resp_rdata_o);
        chk("starts", 4, nts);
        chk("width", 8'h15, {ws[0], ws[1], ws[2], ws[3]});
        run(1'b1, 32'h1000_0000, 2'h0, 128'h1234_5678);
        chk("wdata", 32'h1234_5678, wr_sh);
    end endtask
    task t_burst; begin
        cfg(8'h01, 8'hC0, 16'h0, 1'b0, 1'b0, 4'h0);
        run(1'b0, 32'h1000_0010, 2'h3, 128'h0);
        chk("starts", 1, nts);
        chk("w_hold", 2'h3, w_and);
        chk("attr", 6'h37, {xfer_type_o, xfer_modifier_o, rw_n_o});
        chk("rdata", {4{rd(32'h1000_0010)}}, resp_rdata_o);
    end endtask
    task t_sizes;
        integer s;
    begin
        cfg(8'h01, 8'h00, 16'h0, 1'b0, 1'b1, 4'h0);
        for (s = 0; s < 4; s = s + 1) begin
            run(1'b0, 32'h1000_0020, s[1:0], 128'h0);
            chk("width", s[1:0], ws[0]);
        end
        chk("width", 2'h0, ws[1]);
    end endtask
    task t_nomatch; begin
        cfg(8'h01, 8'h41, 16'h0, 1'b0, 1'b1, 4'h1);
        run(1'b0, 32'h3000_0000, 2'h0, 128'h0);
        chk("cs_n", 8'hFF, cs_seen);
        chk("tip", 32, tip_cnt);
        chk("ack_oe", 1'b0, oe_seen);
    end endtask
    task t_multi; begin
        cfg(8'h03, 8'h41, 16'h0001, 1'b0, 1'b1, 4'h0);
        run(1'b0, 32'h1000_0000, 2'h0, 128'h0);
        chk("cs_n", 8'hFC, cs_seen);
        chk("starts", 1, nts);
        chk("ack_oe", 1'b0, oe_seen);
    end endtask
    task t_dram; begin
        cfg(8'h00, 8'h40, 16'h0, 1'b1, 1'b0, 4'h0);
        run(1'b0, 32'h4000_0000, 2'h0, 128'h0);
        chk("dram", 2'h1, dr_seen);
        chk("cs_n", 8'hFF, cs_seen);
    end endtask
    initial begin
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_read32;
        t_wait;
        t_int_ack;
        t_port8;
        t_burst;
        t_sizes;
        t_nomatch;
        t_multi;
        t_dram;
        close_out;
    end
endmodule // external_bus_transfer_ctrl_tb_top
